//--- hw/umc_uart0_params.svh
// Register map, mode codes and timing counts of the serial channel.
`ifndef UMC_UART0_PARAMS_SVH
`define UMC_UART0_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define UMC_ADDR_MODE 10'h3a0
`define UMC_ADDR_CTL0 10'h3a4
`define UMC_ADDR_BAUD 10'h3a8
`define UMC_ADDR_TXD 10'h3ac
`define UMC_ADDR_RXD 10'h3b0
`define UMC_ADDR_ISTS 10'h3b4
`define UMC_ADDR_IMSK 10'h3b8

// ----------------------------------------------------------------------
// Mode and clock source codes
// ----------------------------------------------------------------------
`define UMC_MD_OFF 3'h0
`define UMC_MD_SYNC 3'h1
`define UMC_MD_ASYNC7 3'h4
`define UMC_MD_ASYNC8 3'h5
`define UMC_MD_ASYNC9 3'h6
`define UMC_CS_DIV1 2'h0
`define UMC_CS_DIV8 2'h1
`define UMC_CS_DIV32 2'h2
`define UMC_NB7 4'h7
`define UMC_NB8 4'h8
`define UMC_NB9 4'h9

// ----------------------------------------------------------------------
// Reset values, masks and counts
// ----------------------------------------------------------------------
`define UMC_RST_BYTE 8'h00
`define UMC_RST_WORD 9'h000
`define UMC_RST_FRAME 13'h0000
`define UMC_RST_IRQ 4'h0
`define UMC_CTL_WMASK 8'he3
`define UMC_PRE_DIV8_LAST 3'h7
`define UMC_PRE_DIV32_LAST 5'h1f
`define UMC_OS_LAST 4'hf
`define UMC_OS_MID 4'h7
`define UMC_SYNC_LAST 4'h7
`define UMC_IRQ_TX 0
`define UMC_IRQ_RX 1
`define UMC_IRQ_PERR 2
`define UMC_IRQ_FERR 3

`endif

//--- hw/umc_pkg.sv
// Types shared by the serial channel control logic.
package umc_pkg;

  // ----------------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic sleep_sel;
    logic parity_on;
    logic parity_type;
    logic stop_length;
    logic clock_direction;
    logic [2:0] mode_sel;
  } umc_mode_t;

  typedef struct packed {
    logic bit_order;
    logic edge_polarity;
    logic open_drain_sel;
    logic rsv_one;
    logic tx_shift_empty;
    logic rsv_zero;
    logic [1:0] count_src;
  } umc_ctl_t;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    UMC_TX_IDLE,
    UMC_TX_ASYNC,
    UMC_TX_SYNC
  } umc_tx_st_t;

  typedef enum logic {
    UMC_RX_IDLE,
    UMC_RX_BUSY
  } umc_rx_st_t;

endpackage

//--- hw/umc_uart0_ctrl.sv
// Mode, control, baud generation and frame engine of one serial channel.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "umc_uart0_params.svh"

module umc_uart0_ctrl (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [9:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o,
  input wire logic rxd_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Builds a frame, LSB first; unused high positions stay 1 as stop bits.
  function automatic logic [12:0] frame_f(input logic [8:0] d, input logic [3:0] nb,
                                          input logic pe, input logic pty);
    logic [12:0] f;
    logic p;
    f = 13'h1fff;
    p = ~pty;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nb)) begin
        f[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    f[0] = 1'b0;
    if (pe) begin
      f[4'(nb + 4'h1)] = p;
    end
    return f;
  endfunction

  // Pulls the data bits back out of a received frame.
  function automatic logic [8:0] data_f(input logic [12:0] f, input logic [3:0] nb);
    logic [8:0] d;
    d = `UMC_RST_WORD;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nb)) begin
        d[i] = f[i+1];
      end
    end
    return d;
  endfunction

  // Mirrors a byte for MSB-first transfers.
  function automatic logic [7:0] rev_f(input logic [7:0] d);
    logic [7:0] r;
    r = `UMC_RST_BYTE;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] mode_r;
  logic [7:0] ctl_r;
  logic [7:0] baud_r;
  logic [8:0] txbuf_r;
  logic [8:0] rxbuf_r;
  logic [3:0] ists_r;
  logic [3:0] imsk_r;
  logic [15:0] rdata_r;
  logic irq_r;
  logic [4:0] pre_r;
  logic [7:0] brg_r;
  logic pin_q_r;
  logic tclk_r;
  umc_pkg::umc_tx_st_t tx_st_r;
  logic [12:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_sub_r;
  logic txo_r;
  umc_pkg::umc_rx_st_t rx_st_r;
  logic [12:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_sub_r;
  logic [7:0] srx_r;
  logic sout_r;
  logic soe_n_r;
  logic cout_r;
  logic coe_n_r;

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  umc_pkg::umc_mode_t cfg;
  umc_pkg::umc_ctl_t ctl;
  wire is_sync = cfg.mode_sel == `UMC_MD_SYNC;
  wire is_a7 = cfg.mode_sel == `UMC_MD_ASYNC7;
  wire is_a8 = cfg.mode_sel == `UMC_MD_ASYNC8;
  wire is_a9 = cfg.mode_sel == `UMC_MD_ASYNC9;
  // Off and forbidden codes fall out of both sets, so nothing runs.
  wire is_async = is_a7 | is_a8 | is_a9;
  wire [3:0] nbits = is_a7 ? `UMC_NB7 : (is_a8 ? `UMC_NB8 : `UMC_NB9);
  wire pe = cfg.parity_on;
  wire [3:0] flen = 4'(nbits + {3'h0, pe} + {3'h0, cfg.stop_length} + 4'h1);
  wire idle_lvl = ~ctl.edge_polarity;
  assign cfg = umc_pkg::umc_mode_t'(mode_r);
  assign ctl = umc_pkg::umc_ctl_t'(ctl_r);

  // ----------------------------------------------------------------------
  // Count source and baud generator
  // ----------------------------------------------------------------------

  // The inhibited source code yields no ticks, so a bad setting stalls rather than runs fast.
  wire src_tick = (ctl.count_src == `UMC_CS_DIV1) ||
                  (ctl.count_src == `UMC_CS_DIV8 && pre_r[2:0] == `UMC_PRE_DIV8_LAST) ||
                  (ctl.count_src == `UMC_CS_DIV32 && pre_r == `UMC_PRE_DIV32_LAST);
  wire brg_tick = src_tick && (brg_r == `UMC_RST_BYTE);
  wire pin_rise = serial_clock_pin_i & ~pin_q_r;
  wire pin_fall = ~serial_clock_pin_i & pin_q_r;
  wire os_tick = cfg.clock_direction ? pin_rise : brg_tick;
  wire in_sync = tx_st_r == umc_pkg::UMC_TX_SYNC;
  wire ext_a = ctl.edge_polarity ? pin_rise : pin_fall;
  wire ext_b = ctl.edge_polarity ? pin_fall : pin_rise;
  wire int_a = brg_tick && (tclk_r == idle_lvl);
  wire int_b = brg_tick && (tclk_r != idle_lvl);
  // The A edge leaves the idle level and drives data; the B edge samples it.
  wire sync_a = in_sync && (cfg.clock_direction ? ext_a : int_a);
  wire sync_b = in_sync && (cfg.clock_direction ? ext_b : int_b);

  // Free running prescaler and reloading baud counter.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_r <= 5'h00;
      brg_r <= `UMC_RST_BYTE;
      pin_q_r <= 1'b1; // Idle level of the pin, so no false edge follows reset.
    end else begin
      pre_r <= 5'(pre_r + 5'h01);
      brg_r <= !src_tick ? brg_r : (brg_tick ? baud_r : 8'(brg_r - 8'h01));
      pin_q_r <= serial_clock_pin_i;
    end
  end

  // Internal transfer clock toggles on each baud tick, so one period is 2(n+1) source ticks.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tclk_r <= 1'b1;
    end else begin
      tclk_r <= (in_sync && brg_tick) ? ~tclk_r : (in_sync ? tclk_r : idle_lvl);
    end
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire wr_mode = wr_i && addr_i == `UMC_ADDR_MODE;
  wire wr_ctl = wr_i && addr_i == `UMC_ADDR_CTL0;
  wire wr_baud = wr_i && addr_i == `UMC_ADDR_BAUD;
  wire wr_txd = wr_i && addr_i == `UMC_ADDR_TXD;
  wire wr_imsk = wr_i && addr_i == `UMC_ADDR_IMSK;
  wire rd_ists = rd_i && addr_i == `UMC_ADDR_ISTS;
  wire tx_idle = tx_st_r == umc_pkg::UMC_TX_IDLE;
  // A data write while busy or disabled is dropped; software polls the empty flag first.
  wire tx_go = wr_txd && tx_idle && (is_sync || is_async);
  wire [7:0] ctl_rd = {ctl_r[7:5], 1'b0, tx_idle, 1'b0, ctl_r[1:0]};
  wire [15:0] rmux = (addr_i == `UMC_ADDR_MODE) ? {8'h00, mode_r} :
                     (addr_i == `UMC_ADDR_CTL0) ? {8'h00, ctl_rd} :
                     (addr_i == `UMC_ADDR_BAUD) ? {8'h00, baud_r} :
                     (addr_i == `UMC_ADDR_TXD) ? {7'h00, txbuf_r} :
                     (addr_i == `UMC_ADDR_RXD) ? {7'h00, rxbuf_r} :
                     (addr_i == `UMC_ADDR_ISTS) ? {12'h000, ists_r} :
                     (addr_i == `UMC_ADDR_IMSK) ? {12'h000, imsk_r} : 16'h0000;

  // ----------------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------------
  wire [12:0] rx_full = rx_sh_r | (13'(rxd_i) << rx_cnt_r);
  wire [8:0] rx_data = data_f(rx_full, nbits);
  wire [12:0] rx_ref = frame_f(rx_data, nbits, pe, cfg.parity_type);
  wire [3:0] pidx = 4'(nbits + 4'h1);
  wire [3:0] sidx = 4'(nbits + {3'h0, pe} + 4'h1);
  wire rx_sample = rx_st_r == umc_pkg::UMC_RX_BUSY && os_tick && rx_sub_r == `UMC_OS_MID;
  wire false_start = rx_sample && rx_cnt_r == 4'h0 && rxd_i;
  wire rx_last = rx_sample && !false_start && rx_cnt_r == sidx;
  wire top_bit = rx_data[4'(nbits - 4'h1)];
  wire rx_keep = !(cfg.sleep_sel && !top_bit);
  wire perr = pe && (rx_full[pidx] != rx_ref[pidx]);
  wire ferr = !rx_full[sidx];
  wire [7:0] srx_nxt = ctl.bit_order ? {srx_r[6:0], rxd_i} : {rxd_i, srx_r[7:1]};
  wire sync_done = sync_b && tx_cnt_r == `UMC_SYNC_LAST;
  wire tx_bit_end = tx_st_r == umc_pkg::UMC_TX_ASYNC && os_tick && tx_sub_r == `UMC_OS_LAST;
  wire async_done = tx_bit_end && tx_cnt_r == flen;
  wire rx_ev = sync_done || (rx_last && rx_keep);
  wire [3:0] ev;
  assign ev[`UMC_IRQ_TX] = sync_done || async_done;
  assign ev[`UMC_IRQ_RX] = rx_ev;
  assign ev[`UMC_IRQ_PERR] = rx_last && rx_keep && perr;
  assign ev[`UMC_IRQ_FERR] = rx_last && rx_keep && ferr;
  // A new event wins over a clearing read in the same cycle.
  wire [3:0] ists_nxt = (rd_ists ? `UMC_RST_IRQ : ists_r) | ev;

  // ----------------------------------------------------------------------
  // Registers and bus answer
  // ----------------------------------------------------------------------

  // Software registers; reserved control bits are not stored and read as zero.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= `UMC_RST_BYTE;
      ctl_r <= `UMC_RST_BYTE;
      baud_r <= `UMC_RST_BYTE;
      txbuf_r <= `UMC_RST_WORD;
      imsk_r <= `UMC_RST_IRQ;
    end else begin
      if (wr_mode) mode_r <= wdata_i[7:0];
      if (wr_ctl) ctl_r <= wdata_i[7:0] & `UMC_CTL_WMASK;
      if (wr_baud) baud_r <= wdata_i[7:0];
      if (tx_go) txbuf_r <= wdata_i[8:0];
      if (wr_imsk) imsk_r <= wdata_i[3:0];
    end
  end

  // Read data stand for one cycle only; status is cleared by its read.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 16'h0000;
      ists_r <= `UMC_RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rd_i ? rmux : 16'h0000;
      ists_r <= ists_nxt;
      irq_r <= |(ists_nxt & imsk_r);
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------

  // Async shifts one frame bit each 16 ticks; sync shifts one byte on A edges.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_st_r <= umc_pkg::UMC_TX_IDLE;
      tx_sh_r <= `UMC_RST_FRAME;
      tx_cnt_r <= 4'h0;
      tx_sub_r <= 4'h0;
      txo_r <= 1'b1;
    end else begin
      case (tx_st_r)
        umc_pkg::UMC_TX_IDLE: begin
          tx_cnt_r <= 4'h0;
          tx_sub_r <= 4'h0;
          txo_r <= 1'b1;
          if (tx_go && is_sync) begin
            tx_st_r <= umc_pkg::UMC_TX_SYNC;
            tx_sh_r <= {5'h1f, ctl.bit_order ? rev_f(wdata_i[7:0]) : wdata_i[7:0]};
          end else if (tx_go) begin
            tx_st_r <= umc_pkg::UMC_TX_ASYNC;
            tx_sh_r <= frame_f(wdata_i[8:0], nbits, pe, cfg.parity_type);
            txo_r <= 1'b0;
          end
        end
        umc_pkg::UMC_TX_ASYNC: begin
          if (os_tick) tx_sub_r <= 4'(tx_sub_r + 4'h1);
          if (async_done) begin
            tx_st_r <= umc_pkg::UMC_TX_IDLE;
            txo_r <= 1'b1;
          end else if (tx_bit_end) begin
            tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
            txo_r <= tx_sh_r[1];
            tx_sh_r <= {1'b1, tx_sh_r[12:1]};
          end
        end
        umc_pkg::UMC_TX_SYNC: begin
          if (sync_a) begin
            txo_r <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[12:1]};
          end
          if (sync_b) tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
          if (sync_done) tx_st_r <= umc_pkg::UMC_TX_IDLE;
        end
        default: tx_st_r <= umc_pkg::UMC_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------

  // Async start is found on a tick and confirmed at mid bit, which rejects short glitches.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_st_r <= umc_pkg::UMC_RX_IDLE;
      rx_sh_r <= `UMC_RST_FRAME;
      rx_cnt_r <= 4'h0;
      rx_sub_r <= 4'h0;
    end else begin
      case (rx_st_r)
        umc_pkg::UMC_RX_IDLE: begin
          rx_cnt_r <= 4'h0;
          rx_sub_r <= 4'h1;
          rx_sh_r <= `UMC_RST_FRAME;
          if (is_async && os_tick && !rxd_i) rx_st_r <= umc_pkg::UMC_RX_BUSY;
        end
        umc_pkg::UMC_RX_BUSY: begin
          if (os_tick) rx_sub_r <= 4'(rx_sub_r + 4'h1);
          if (false_start || rx_last || !is_async) rx_st_r <= umc_pkg::UMC_RX_IDLE;
          if (rx_sample) begin
            rx_sh_r <= rx_full;
            rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
          end
        end
        default: rx_st_r <= umc_pkg::UMC_RX_IDLE;
      endcase
    end
  end

  // Sync bits are taken on B edges; the buffer is shared by both modes.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      srx_r <= `UMC_RST_BYTE;
      rxbuf_r <= `UMC_RST_WORD;
    end else begin
      if (sync_b) srx_r <= srx_nxt;
      if (sync_done) rxbuf_r <= {1'b0, srx_nxt};
      else if (rx_last && rx_keep) rxbuf_r <= rx_data;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------

  // Open drain only ever pulls low, so a high bit releases the pin instead of driving it.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sout_r <= 1'b1;
      soe_n_r <= 1'b0;
      cout_r <= 1'b1;
      coe_n_r <= 1'b1;
    end else begin
      sout_r <= ctl.open_drain_sel ? 1'b0 : txo_r;
      soe_n_r <= ctl.open_drain_sel ? txo_r : 1'b0;
      cout_r <= tclk_r;
      coe_n_r <= !(is_sync && !cfg.clock_direction);
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign serial_out_pin_o = sout_r;
  assign serial_out_pin_oe_n_o = soe_n_r;
  assign serial_clock_pin_o = cout_r;
  assign serial_clock_pin_oe_n_o = coe_n_r;

endmodule // umc_uart0_ctrl

//--- tb/umc_uart0_ctrl_properties.sv
// Port-level assertions of the serial channel control block.
`timescale 1ns/1ps
`include "umc_uart0_params.svh"
module umc_uart0_ctrl_properties (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [9:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic irq_o,
  input wire logic rxd_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_n_o,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Shadow of the drive-type bit, since the pin enable depends on it.
  logic od_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      od_r <= 1'b0;
    end else if (wr_i && addr_i == `UMC_ADDR_CTL0) begin
      od_r <= wdata_i[5];
    end
  end

  // ----------------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------------
  sequence s_mode_wr;
    wr_i && addr_i == `UMC_ADDR_MODE;
  endsequence
  sequence s_mode_rd;
    rd_i && addr_i == `UMC_ADDR_MODE;
  endsequence
  property p_mode_rb;
    s_mode_wr ##1 s_mode_rd |=> rdata_o == {8'h00, $past(wdata_i[7:0], 2)};
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_ctl_rsv;
    rd_i && addr_i == `UMC_ADDR_CTL0 |=> rdata_o[15:8] == 8'h00 && !rdata_o[4] && !rdata_o[2];
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("reserved bits read");
  property p_unmapped;
    rd_i && addr_i == 10'h3bc |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_off;
    wr_i && addr_i == `UMC_ADDR_IMSK && wdata_i[3:0] == 4'h0 ##1
      !(wr_i && addr_i == `UMC_ADDR_IMSK) |=> !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");

  // ----------------------------------------------------------------------
  // Pin side
  // ----------------------------------------------------------------------
  property p_clk_oe;
    s_mode_wr |-> ##2 serial_clock_pin_oe_n_o == ($past(wdata_i[3:0], 2) != 4'h1);
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock pin enable wrong");
  property p_od_pp;
    !od_r && $stable(od_r) |-> !serial_out_pin_oe_n_o;
  endproperty
  a_od_pp: assert property (p_od_pp) else $error("push-pull not driving");
  property p_od_rel;
    od_r && $stable(od_r) |-> !serial_out_pin_o;
  endproperty
  a_od_rel: assert property (p_od_rel) else $error("open-drain drives high");
  property p_reset_idle;
    $rose(resetn_i) |-> serial_out_pin_o && !serial_out_pin_oe_n_o && serial_clock_pin_oe_n_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle");
endmodule // umc_uart0_ctrl_properties

bind umc_uart0_ctrl umc_uart0_ctrl_properties i_umc_uart0_ctrl_properties (.clock_i, .resetn_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .rxd_i, .serial_out_pin_o,
  .serial_out_pin_oe_n_o, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe_n_o);

//--- tb/umc_serial_peer.sv
// Behavioural serial peer on the line side of the channel.
`timescale 1ns/1ps
module umc_serial_peer (
  input wire logic clock_i,
  input wire logic txd_i,
  input wire logic sck_i,
  output logic rxd_o,
  output logic ext_clk_o
);
  int cyc = 0;
  // Receive line has a pull-up, and the peer's clock stands high outside frames.
  initial begin
    rxd_o = 1'b1;
    ext_clk_o = 1'b1;
  end
  always @(posedge clock_i) cyc <= cyc + 1;

  // Bounded wait for a level on the data (0) or clock (1) line.
  task automatic wait_lvl(input logic v, input logic sel);
    for (int k = 0; k < 3000 && ((sel ? sck_i : txd_i) !== v); k++) @(posedge clock_i);
  endtask

  // Start, data LSB first, parity, stop; 16 ticks of 4 cycles per bit. With ext set
  // the peer also makes those ticks on the clock pin.
  task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic par,
                      input logic stop, input logic ext);
    for (int i = -1; i <= nb + 1; i++) begin
      rxd_o <= (i < 0) ? 1'b0 : (i < nb) ? d[i] : (i == nb && pe) ? par : stop;
      repeat (16) begin
        ext_clk_o <= ~ext;
        repeat (2) @(posedge clock_i);
        ext_clk_o <= 1'b1;
        repeat (2) @(posedge clock_i);
      end
    end
    rxd_o <= 1'b1;
  endtask

  // Catch an async frame at mid-bit, 64 cycles per bit.
  task automatic catch(input int nb, output logic [11:0] f);
    f = '0;
    wait_lvl(1'b0, 1'b0);
    repeat (32) @(posedge clock_i);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd_i;
      repeat (64) @(posedge clock_i);
    end
  endtask

  // Sync exchange: peer shifts out on falling, samples on rising, first bit taken as MSB.
  task automatic xchg(input logic [7:0] s, output logic [7:0] r, output int per);
    int t0;
    for (int i = 7; i >= 0; i--) begin
      wait_lvl(1'b0, 1'b1);
      rxd_o <= s[i];
      wait_lvl(1'b1, 1'b1);
      r[i] = txd_i;
      if (i == 7) t0 = cyc;
      if (i == 6) per = cyc - t0;
    end
    rxd_o <= ~s[0];
  endtask
endmodule // umc_serial_peer

//--- tb/umc_uart0_ctrl_tb.sv
// Self-checking testbench of the serial channel control block.
`timescale 1ns/1ps
`include "umc_uart0_params.svh"
module umc_uart0_ctrl_tb;
  logic clock_i, resetn_i, wr_i, rd_i, rxd_i, ext_clk, irq_o, txd, txd_oe_n, sck, sck_oe_n;
  logic [9:0] addr_i;
  logic [15:0] wdata_i, rdata_o, v;
  logic [11:0] f;
  logic [7:0] r;
  int per, mismatches, n_checks;
  logic [7:0] md [5] = '{8'h4c, 8'hcc, 8'hcc, 8'h4c, 8'h4c};
  logic [6:0] dt [5] = '{7'h35, 7'h35, 7'h55, 7'h2a, 7'h11};
  logic [3:0] st [5] = '{4'h2, 4'h0, 4'h2, 4'h6, 4'ha};
  logic [8:0] rx [5] = '{9'h035, 9'h035, 9'h055, 9'h1ff, 9'h1ff};
  logic [4:0] pf = 5'b01000;
  logic [4:0] sp = 5'b01111;
  // Pin levels: pull-up on the data line, the clock pin shared with the peer.
  wire txd_line = txd_oe_n ? 1'b1 : txd;
  wire sck_line = sck_oe_n ? ext_clk : sck;

  umc_uart0_ctrl i_umc_uart0_ctrl (.clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .irq_o, .rxd_i, .serial_out_pin_o(txd), .serial_out_pin_oe_n_o(txd_oe_n),
    .serial_clock_pin_i(sck_line), .serial_clock_pin_o(sck), .serial_clock_pin_oe_n_o(sck_oe_n));
  umc_serial_peer i_umc_serial_peer (.clock_i, .txd_i(txd_line), .sck_i(sck_line),
    .rxd_o(rxd_i), .ext_clk_o(ext_clk));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------------
  // Bus tasks; a write holds its strobe until the next call or idle.
  // ----------------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
  endtask
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [15:0] e, input string nm);
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, e, rdata_o);
    @(posedge clock_i);
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs under 8000 cycles.
  initial begin
    repeat (30000) @(posedge clock_i);
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 10'h000;
    wdata_i = 16'h0000;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    rdchk(`UMC_ADDR_MODE, 16'h0000, "mode reset");
    rdchk(`UMC_ADDR_CTL0, 16'h0008, "ctl0 reset");
    rdchk(10'h3bc, 16'h0000, "unmapped");
    // A data write while the channel is off must be dropped whole.
    wr(`UMC_ADDR_TXD, 16'h00aa);
    rdchk(`UMC_ADDR_TXD, 16'h0000, "tx while off");
    rdchk(`UMC_ADDR_CTL0, 16'h0008, "flag while off");
    for (int c = 0; c < 3; c++) begin
      wr(`UMC_ADDR_CTL0, 16'h0010 | c[15:0]);
      rdchk(`UMC_ADDR_CTL0, 16'h0008 | c[15:0], "count source");
    end
    wr(`UMC_ADDR_CTL0, 16'h00f2);
    rdchk(`UMC_ADDR_CTL0, 16'h00ea, "ctl0 bits");
    wr(`UMC_ADDR_CTL0, 16'h0010);
    wr(`UMC_ADDR_MODE, 16'h0075);
    rdchk(`UMC_ADDR_MODE, 16'h0075, "mode bits");
    // Async 8-bit send, even parity, two stops; a second write while busy is dropped.
    wr(`UMC_ADDR_BAUD, 16'h0003);
    wr(`UMC_ADDR_IMSK, 16'h000e);
    wr(`UMC_ADDR_TXD, 16'h00a5);
    fork
      i_umc_serial_peer.catch(12, f);
      begin
        idle(40);
        wr(`UMC_ADDR_TXD, 16'h0055);
        rdchk(`UMC_ADDR_CTL0, 16'h0000, "flag busy");
        rdchk(`UMC_ADDR_TXD, 16'h00a5, "busy write");
      end
    join
    chk("tx frame", {4'h0, 2'b11, ^8'ha5, 8'ha5, 1'b0}, {4'h0, f});
    rdchk(`UMC_ADDR_CTL0, 16'h0008, "flag idle");
    chk("irq masked", 16'h0000, {15'h0, irq_o});
    rdchk(`UMC_ADDR_ISTS, 16'h0001, "tx done");
    // Async 7-bit receive on the pin clock, odd parity, sleep and error frames.
    wr(`UMC_ADDR_IMSK, 16'h000f);
    for (int i = 0; i < 5; i++) begin
      wr(`UMC_ADDR_MODE, {8'h00, md[i]});
      idle(2);
      i_umc_serial_peer.send({2'b00, dt[i]}, 7, 1'b1, (~^dt[i]) ^ pf[i], sp[i], 1'b1);
      idle(40);
      chk("irq", {15'h0, st[i] != 4'h0}, {15'h0, irq_o});
      rdchk(`UMC_ADDR_ISTS, {12'h0, st[i]}, "rx status");
      if (rx[i] !== 9'h1ff) rdchk(`UMC_ADDR_RXD, {7'h0, rx[i]}, "rx data");
      idle(2);
      chk("irq cleared", 16'h0000, {15'h0, irq_o});
    end
    // Sync exchanges: MSB first on clk with n=3, LSB first on clk/8 with n=0.
    for (int i = 0; i < 2; i++) begin
      wr(`UMC_ADDR_MODE, 16'h0001);
      wr(`UMC_ADDR_CTL0, i ? 16'h0011 : 16'h0090);
      wr(`UMC_ADDR_BAUD, i ? 16'h0000 : 16'h0003);
      wr(`UMC_ADDR_TXD, 16'h003c);
      idle(0);
      i_umc_serial_peer.xchg(8'hc5, r, per);
      chk("sync tx", {8'h0, i ? rev8(8'h3c) : 8'h3c}, {8'h0, r});
      chk("sync period", i ? 16'd16 : 16'd8, per[15:0]);
      idle(40);
      rdchk(`UMC_ADDR_RXD, {8'h0, i ? rev8(8'hc5) : 8'hc5}, "sync rx");
    end
    wr(`UMC_ADDR_IMSK, 16'h0000);
    idle(4);
    print_verdict();
  end
endmodule // umc_uart0_ctrl_tb
